// *** verilog/fbp_flash_ctrl.sv ***
/*
  Flash array with background row programming, sector erase, erase abort
  and single-bit correcting read path.
  Assumes requesters on mclk; the system clock is the 80 MHz flash clock.
*/
// Operation
// - Program one whole 32-byte row only
// - Erase works on whole sectors at least
// - Single or multiple sectors erased together
// - One byte per read, three CPU periods
// - Erased and delivered cells read zero
// - Check bits correct single-bit read errors
// - Program and erase run in background
// - Erase abort ends erase early
// - Row program lasts 209440 clock cycles
// - Sector erase lasts 8175360 clock cycles
// - No single-row erase, sector only
// - Four 4-Kbyte banks, bank zero data
// - Both bank types hold code, data
// - Application and boot loader both program
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_ctrl #(
  parameter int unsigned PROG_CYC = fbp_pkg::PROG_CYC_DEF,
  parameter int unsigned ERASE_CYC = fbp_pkg::ERASE_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rd_req,
  input wire logic [fbp_pkg::ADDR_W-1:0] rd_addr,
  output logic rd_ack,
  output logic [7:0] rd_data,
  input wire logic ld_valid,
  input wire logic [fbp_pkg::COL_W-1:0] ld_idx,
  input wire logic [7:0] ld_data,
  input wire logic prog_req,
  input wire logic [fbp_pkg::ROW_W-1:0] prog_row,
  input wire logic prog_src,
  input wire logic erase_req,
  input wire logic [fbp_pkg::BANK_W-1:0] erase_bank,
  input wire logic [fbp_pkg::SECT_W-1:0] erase_sectors,
  input wire logic abort_req,
  output logic busy,
  output logic op_done,
  output logic op_src,
  output logic nmi_flash,
  output logic nmi_ecc
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] ecc_enc(input logic [7:0] d);
    logic [11:0] c;
    c = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 2'b00};
    c[0] = c[2] ^ c[4] ^ c[6] ^ c[8] ^ c[10];
    c[1] = c[2] ^ c[5] ^ c[6] ^ c[9] ^ c[10];
    c[3] = c[4] ^ c[5] ^ c[6] ^ c[11];
    c[7] = c[8] ^ c[9] ^ c[10] ^ c[11];
    return c;
  endfunction
  function automatic logic [3:0] ecc_syn(input logic [11:0] c);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < 12; i++) begin
      s = s ^ (c[i] ? 4'(i + 1) : 4'h0);
    end
    return s;
  endfunction
  function automatic logic [7:0] ecc_dec(input logic [11:0] c);
    logic [11:0] f;
    logic [3:0] s;
    f = c;
    s = ecc_syn(c);
    if (s != 4'h0 && s <= 4'hc) begin
      f[s - 4'h1] = ~f[s - 4'h1];
    end
    return {f[11:8], f[6:4], f[2]};
  endfunction
  function automatic logic [2:0] sect_of(input logic [1:0] bank, input logic [6:0] r);
    return bank == fbp_pkg::DATA_BANK ? r[6:fbp_pkg::DSECT_LSB] : {1'b0, r[6:fbp_pkg::PSECT_LSB]};
  endfunction
  // ----------------------------------------------------------------
  // Array and row buffer
  // ----------------------------------------------------------------
  logic [11:0] mem [0:16383];
  logic [7:0] rowbuf [0:31];
  logic [11:0] mem_q;
  logic mem_we;
  logic [fbp_pkg::ADDR_W-1:0] mem_wa;
  logic [11:0] mem_wd;
  logic [fbp_pkg::ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
  always_ff @(posedge mclk) begin
    if (ld_valid) begin
      rowbuf[ld_idx] <= ld_data;
    end
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    mem_q <= mem[rd_addr_r];
  end
  // ----------------------------------------------------------------
  // Program and erase sequencer
  // ----------------------------------------------------------------
  fbp_pkg::fbp_state_e state_r, state_nxt;
  logic [fbp_pkg::TMR_W-1:0] tmr_r, tmr_nxt;
  logic [fbp_pkg::ROW_W-1:0] row_r, row_nxt;
  logic [fbp_pkg::BANK_W-1:0] bank_r, bank_nxt;
  logic [fbp_pkg::SECT_W-1:0] sect_r, sect_nxt;
  logic [fbp_pkg::ROWS-1:0] used_r, used_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, src_r, src_nxt;
  logic nmif_r, nmif_nxt;
  logic prog_take, erase_take, refuse, aborting;
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    row_nxt = row_r;
    bank_nxt = bank_r;
    sect_nxt = sect_r;
    used_nxt = used_r;
    src_nxt = src_r;
    done_nxt = 1'b0;
    mem_we = 1'b0;
    mem_wa = {row_r, tmr_r[fbp_pkg::COL_W-1:0]};
    mem_wd = ecc_enc(rowbuf[tmr_r[fbp_pkg::COL_W-1:0]]);
    prog_take = 1'b0;
    erase_take = 1'b0;
    refuse = 1'b0;
    aborting = 1'b0;
    case (state_r)
      fbp_pkg::FBP_IDLE: begin
        if (prog_req) begin
          prog_take = 1'b1;
          state_nxt = fbp_pkg::FBP_PROG;
          row_nxt = prog_row;
          bank_nxt = prog_row[fbp_pkg::ROW_W-1:fbp_pkg::BANK_ROW_W];
          src_nxt = prog_src;
          tmr_nxt = '0;
        end else if (erase_req) begin
          if (erase_sectors == '0) begin
            refuse = 1'b1;
          end else begin
            erase_take = 1'b1;
            state_nxt = fbp_pkg::FBP_ERASE;
            bank_nxt = erase_bank;
            sect_nxt = erase_sectors;
            tmr_nxt = '0;
          end
        end
      end
      fbp_pkg::FBP_PROG: begin
        refuse = prog_req | erase_req;
        if (tmr_r < fbp_pkg::TMR_W'(fbp_pkg::ROW_BYTES)) begin
          mem_we = 1'b1;
          used_nxt[row_r] = 1'b1;
        end
        if (tmr_r == fbp_pkg::TMR_W'(PROG_CYC - 1)) begin
          state_nxt = fbp_pkg::FBP_IDLE;
          done_nxt = 1'b1;
        end else begin
          tmr_nxt = tmr_r + 1'b1;
        end
      end
      fbp_pkg::FBP_ERASE: begin
        refuse = prog_req | erase_req;
        if (abort_req) begin
          aborting = 1'b1;
          state_nxt = fbp_pkg::FBP_IDLE;
        end else if (tmr_r == fbp_pkg::TMR_W'(ERASE_CYC - 1)) begin
          state_nxt = fbp_pkg::FBP_IDLE;
          done_nxt = 1'b1;
          for (int r = 0; r < fbp_pkg::BANK_ROWS; r++) begin
            if (sect_r[sect_of(bank_r, 7'(r))]) begin
              used_nxt[{bank_r, 7'(r)}] = 1'b0;
            end
          end
        end else begin
          tmr_nxt = tmr_r + 1'b1;
        end
      end
      default: begin
        state_nxt = fbp_pkg::FBP_IDLE;
      end
    endcase
    busy_nxt = state_nxt != fbp_pkg::FBP_IDLE;
    nmif_nxt = refuse | aborting;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= fbp_pkg::FBP_IDLE;
      tmr_r <= '0;
      row_r <= '0;
      bank_r <= '0;
      sect_r <= '0;
      used_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      src_r <= 1'b0;
      nmif_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      row_r <= row_nxt;
      bank_r <= bank_nxt;
      sect_r <= sect_nxt;
      used_r <= used_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      src_r <= src_nxt;
      nmif_r <= nmif_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic rd_act_r, rd_act_nxt, ack_r, ack_nxt, nmie_r, nmie_nxt;
  logic [3:0] rd_cnt_r, rd_cnt_nxt;
  logic [7:0] rdat_r, rdat_nxt;
  logic rd_take, rd_conf, row_ok, ecc_fix;
  always_comb begin
    rd_act_nxt = rd_act_r;
    rd_cnt_nxt = rd_cnt_r;
    rd_addr_nxt = rd_addr_r;
    rdat_nxt = rdat_r;
    ack_nxt = 1'b0;
    nmie_nxt = 1'b0;
    // Stall reads of the busy bank
    rd_conf = busy_r && rd_addr[fbp_pkg::ADDR_W-1:fbp_pkg::ADDR_W-fbp_pkg::BANK_W] == bank_r;
    rd_take = rd_req && !rd_act_r && !ack_r && !rd_conf;
    row_ok = used_r[rd_addr_r[fbp_pkg::ADDR_W-1:fbp_pkg::COL_W]];
    ecc_fix = row_ok && ecc_syn(mem_q) != 4'h0;
    if (rd_take) begin
      rd_act_nxt = 1'b1;
      rd_cnt_nxt = '0;
      rd_addr_nxt = rd_addr;
    end else if (rd_act_r) begin
      rd_cnt_nxt = rd_cnt_r + 1'b1;
      if (rd_cnt_r == fbp_pkg::RD_ACK_AT) begin
        rd_act_nxt = 1'b0;
        ack_nxt = 1'b1;
        rdat_nxt = row_ok ? ecc_dec(mem_q) : 8'h00;
        nmie_nxt = ecc_fix;
      end
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_act_r <= 1'b0;
      rd_cnt_r <= '0;
      rd_addr_r <= '0;
      rdat_r <= 8'h00;
      ack_r <= 1'b0;
      nmie_r <= 1'b0;
    end else begin
      rd_act_r <= rd_act_nxt;
      rd_cnt_r <= rd_cnt_nxt;
      rd_addr_r <= rd_addr_nxt;
      rdat_r <= rdat_nxt;
      ack_r <= ack_nxt;
      nmie_r <= nmie_nxt;
    end
  end
  assign rd_ack = ack_r;
  assign rd_data = rdat_r;
  assign busy = busy_r;
  assign op_done = done_r;
  assign op_src = src_r;
  assign nmi_flash = nmif_r;
  assign nmi_ecc = nmie_r;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rd_lat;
    @(posedge mclk) disable iff (rst) rd_take |-> ##9 rd_ack;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_stall;
    @(posedge mclk) disable iff (rst) rd_req && rd_conf && !rd_act_r |=> !rd_act_r;
  endproperty
  a_rd_stall: assert property (p_rd_stall) else $error("read of busy bank");
  property p_erased;
    @(posedge mclk) disable iff (rst) rd_ack && !$past(row_ok) |-> rd_data == 8'h00;
  endproperty
  a_erased: assert property (p_erased) else $error("erased byte not zero");
  property p_ecc_evt;
    @(posedge mclk) disable iff (rst) rd_ack && $past(ecc_fix) |-> nmi_ecc;
  endproperty
  a_ecc_evt: assert property (p_ecc_evt) else $error("ecc event lost");
  property p_prog_tmr;
    @(posedge mclk) disable iff (rst)
      state_r == fbp_pkg::FBP_PROG |-> tmr_r < fbp_pkg::TMR_W'(PROG_CYC);
  endproperty
  a_prog_tmr: assert property (p_prog_tmr) else $error("program overran");
  property p_erase_tmr;
    @(posedge mclk) disable iff (rst)
      state_r == fbp_pkg::FBP_ERASE |-> tmr_r < fbp_pkg::TMR_W'(ERASE_CYC);
  endproperty
  a_erase_tmr: assert property (p_erase_tmr) else $error("erase overran");
  property p_row_wr;
    @(posedge mclk) disable iff (rst) prog_take |=> mem_we [*8];
  endproperty
  a_row_wr: assert property (p_row_wr) else $error("row write stopped");
  property p_busy;
    @(posedge mclk) disable iff (rst) (prog_take || erase_take) |=> busy && !op_done;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");
  property p_abort;
    @(posedge mclk) disable iff (rst)
      state_r == fbp_pkg::FBP_ERASE && abort_req |=> !busy && nmi_flash && !op_done;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_refuse;
    @(posedge mclk) disable iff (rst) busy && (prog_req || erase_req) |=> nmi_flash;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refusal not flagged");
endmodule
`default_nettype wire

// *** verilog/fbp_pkg.sv ***
/*
  Shared constants and types of the flash bank program/erase sequencer.
  Assumes one system clock; the CPU clock is a fixed division of it.
*/
`default_nettype none
package fbp_pkg;
  localparam int unsigned NUM_BANKS = 4;
  localparam int unsigned BANK_W = 2;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned ROW_W = 9;
  localparam int unsigned ROWS = 512;
  localparam int unsigned BANK_ROWS = 128;
  localparam int unsigned BANK_ROW_W = 7;
  localparam int unsigned ROW_BYTES = 32;
  localparam int unsigned COL_W = 5;
  localparam int unsigned SECT_W = 8;
  localparam int unsigned CW_W = 12;
  localparam int unsigned TMR_W = 24;
  localparam logic [1:0] DATA_BANK = 2'h0;
  // Data bank: eight sectors of 16 rows; program banks: four of 32 rows
  localparam int unsigned DSECT_LSB = 4;
  localparam int unsigned PSECT_LSB = 5;
  localparam int unsigned CPU_DIV = 3;
  localparam int unsigned READ_CPU_CYC = 3;
  localparam int unsigned READ_CYC = CPU_DIV * READ_CPU_CYC;
  localparam logic [3:0] RD_ACK_AT = 4'(READ_CYC - 2);
  localparam int unsigned PROG_CYC_DEF = 209440;
  localparam int unsigned ERASE_CYC_DEF = 8175360;

  typedef enum logic [1:0] {
    FBP_IDLE = 2'b00,
    FBP_PROG = 2'b01,
    FBP_ERASE = 2'b10
  } fbp_state_e;
endpackage
`default_nettype wire

// *** tb/fbp_cpu_model.sv ***
/*
  Requester model: CPU core doing byte reads, row loads, program, erase, abort.
  Assumes the mclk rising edge and the controller's hand-over timing.
*/
`timescale 1ns/1ps
`default_nettype none
module fbp_cpu_model (
  input wire logic mclk,
  input wire logic rd_ack,
  input wire logic [7:0] rd_data,
  input wire logic op_done,
  input wire logic nmi_flash,
  output logic rd_req,
  output logic [fbp_pkg::ADDR_W-1:0] rd_addr,
  output logic ld_valid,
  output logic [fbp_pkg::COL_W-1:0] ld_idx,
  output logic [7:0] ld_data,
  output logic prog_req,
  output logic [fbp_pkg::ROW_W-1:0] prog_row,
  output logic prog_src,
  output logic erase_req,
  output logic [fbp_pkg::BANK_W-1:0] erase_bank,
  output logic [fbp_pkg::SECT_W-1:0] erase_sectors,
  output logic abort_req
);
  // ----------------------------
  // Requester tasks
  // ----------------------------
  initial begin
    {rd_req, ld_valid, prog_req, prog_src, erase_req, abort_req} = 6'h00;
    {rd_addr, ld_idx, ld_data, prog_row, erase_bank, erase_sectors} = '0;
  end

  task automatic rd(input logic [13:0] a, output logic [7:0] d, output int n);
    n = 0;
    rd_req = 1'b1;
    rd_addr = a;
    do begin
      @(posedge mclk);
      n++;
    end while (!rd_ack && n < 2000);
    d = rd_data;
    #1;
    rd_req = 1'b0;
    rd_addr = ~a;
    @(posedge mclk);
    #1;
  endtask

  task automatic load(input logic [7:0] s);
    for (int k = 0; k < 32; k++) begin
      ld_valid = 1'b1;
      ld_idx = 5'(k);
      ld_data = s ^ 8'(k * 7);
      @(posedge mclk);
      #1;
    end
    ld_valid = 1'b0;
    ld_data = ~ld_data;
  endtask

  task automatic prog(input logic [8:0] r, input logic s);
    prog_req = 1'b1;
    prog_row = r;
    prog_src = s;
    @(posedge mclk);
    #1;
    prog_req = 1'b0;
    prog_row = ~r;
  endtask

  task automatic erase(input logic [1:0] b, input logic [7:0] m);
    erase_req = 1'b1;
    erase_bank = b;
    erase_sectors = m;
    @(posedge mclk);
    #1;
    erase_req = 1'b0;
    erase_sectors = ~m;
  endtask

  task automatic abrt();
    abort_req = 1'b1;
    @(posedge mclk);
    #1;
    abort_req = 1'b0;
  endtask

  task automatic wait_op(output int n, output logic dn);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!op_done && !nmi_flash && n < 30000);
    dn = op_done;
    #1;
  endtask
endmodule
`default_nettype wire

// *** tb/fbp_flash_ctrl_bench.sv ***
/*
  Self-checking bench of the flash controller, one task per scenario.
  Assumes shortened program and erase counts.
*/
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_ctrl_bench;
  localparam int PC = 64;
  localparam int EC = 100;
  logic mclk, rst, rd_req, rd_ack, ld_valid, prog_req, prog_src, erase_req, abort_req;
  logic busy, op_done, op_src, nmi_flash, nmi_ecc, dn;
  logic [13:0] rd_addr;
  logic [7:0] rd_data, ld_data, erase_sectors, d;
  logic [4:0] ld_idx;
  logic [8:0] prog_row;
  logic [1:0] erase_bank;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n, n2;
  int ecc_seen = 0;

  fbp_flash_ctrl #(.PROG_CYC(PC), .ERASE_CYC(EC)) fbp_flash_ctrl_i (.mclk, .rst, .rd_req,
    .rd_addr, .rd_ack, .rd_data, .ld_valid, .ld_idx, .ld_data, .prog_req, .prog_row, .prog_src,
    .erase_req, .erase_bank, .erase_sectors, .abort_req, .busy, .op_done, .op_src, .nmi_flash,
    .nmi_ecc);
  fbp_cpu_model fbp_cpu_model_i (.mclk, .rd_ack, .rd_data, .op_done, .nmi_flash, .rd_req,
    .rd_addr, .ld_valid, .ld_idx, .ld_data, .prog_req, .prog_row, .prog_src, .erase_req,
    .erase_bank, .erase_sectors, .abort_req);

  // ----------------------------
  // Clock, checks, closing
  // ----------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string w);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, w, got, exp);
    end
  endtask

  function automatic logic [7:0] pat(input logic [7:0] s, input int k);
    return s ^ 8'(k * 7);
  endfunction

  task automatic conclude();
    $display("mismatches %0d, checks %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (nmi_ecc !== 1'b0) begin
      ecc_seen <= ecc_seen + 1;
    end
    if (cyc == 8000) begin
      fail_count++;
      $display("[ERR] %0t run too long", $time);
      conclude();
    end
  end

  // ----------------------------
  // Scenarios
  // ----------------------------
  task automatic t_reset();
    check({busy, op_done, nmi_flash}, 0, "idle");
    fbp_cpu_model_i.rd(14'h0000, d, n);
    check(d, 0, "erased");
    check(n, 10, "read time");
    fbp_cpu_model_i.rd(14'h2fe1, d, n);
    check(d, 0, "erased");
  endtask

  task automatic t_prog();
    fbp_cpu_model_i.load(8'h5a);
    fbp_cpu_model_i.prog(9'h080, 1'b1);
    @(posedge mclk);
    #1;
    check(busy, 1, "busy");
    fbp_cpu_model_i.wait_op(n, dn);
    check({dn, busy, op_src}, 3'b101, "done");
    check(n, PC, "prog time");
    for (int k = 0; k < 32; k++) begin
      fbp_cpu_model_i.rd({9'h080, 5'(k)}, d, n);
      check(d, pat(8'h5a, k), "row byte");
    end
    check(ecc_seen, 0, "ecc events");
  endtask

  task automatic t_stall();
    fbp_cpu_model_i.load(8'h33);
    fbp_cpu_model_i.prog(9'h010, 1'b0);
    fork
      fbp_cpu_model_i.wait_op(n, dn);
      begin
        fbp_cpu_model_i.rd(14'h1000, d, n2);
        check(n2, 10, "other bank");
        check(d, pat(8'h5a, 0), "code in bank");
        fbp_cpu_model_i.rd({9'h010, 5'h03}, d, n2);
      end
    join
    check(d, pat(8'h33, 3), "stalled read");
    check(n2 > 20, 1, "stall");
    check(op_src, 0, "source");
  endtask

  task automatic t_refuse();
    fbp_cpu_model_i.load(8'h0f);
    fbp_cpu_model_i.prog(9'h000, 1'b0);
    fbp_cpu_model_i.erase(2'h1, 8'h01);
    fbp_cpu_model_i.wait_op(n, dn);
    check({dn, n < 4}, 2'b01, "busy refusal");
    fbp_cpu_model_i.wait_op(n, dn);
    check(dn, 1, "program kept");
    fbp_cpu_model_i.erase(2'h0, 8'h00);
    fbp_cpu_model_i.wait_op(n, dn);
    check({dn, busy, n < 4}, 3'b001, "empty mask");
  endtask

  task automatic t_erase();
    fbp_cpu_model_i.load(8'h44);
    fbp_cpu_model_i.prog(9'h020, 1'b0);
    fbp_cpu_model_i.wait_op(n, dn);
    fbp_cpu_model_i.erase(2'h0, 8'h01);
    fbp_cpu_model_i.wait_op(n, dn);
    check(dn, 1, "erase done");
    check(n, EC + 1, "erase time");
    fbp_cpu_model_i.rd({9'h000, 5'h05}, d, n);
    check(d, 0, "sector clear");
    fbp_cpu_model_i.rd({9'h010, 5'h05}, d, n);
    check(d, pat(8'h33, 5), "next sector");
    fbp_cpu_model_i.erase(2'h0, 8'h06);
    fbp_cpu_model_i.wait_op(n, dn);
    fbp_cpu_model_i.rd({9'h010, 5'h05}, d, n);
    check(d, 0, "multi sector");
    fbp_cpu_model_i.rd({9'h020, 5'h1f}, d, n);
    check(d, 0, "multi sector");
    fbp_cpu_model_i.rd({9'h080, 5'h05}, d, n);
    check(d, pat(8'h5a, 5), "other bank");
  endtask

  task automatic t_abort();
    fbp_cpu_model_i.load(8'h21);
    fbp_cpu_model_i.prog(9'h000, 1'b0);
    fbp_cpu_model_i.wait_op(n, dn);
    fbp_cpu_model_i.erase(2'h0, 8'h01);
    repeat (5) @(posedge mclk);
    #1;
    fbp_cpu_model_i.abrt();
    fbp_cpu_model_i.wait_op(n, dn);
    check({dn, busy, n < 3}, 3'b001, "abort");
    fbp_cpu_model_i.rd({9'h000, 5'h09}, d, n);
    check(d, pat(8'h21, 9), "kept");
  endtask

  initial begin
    rst = 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    t_prog();
    t_stall();
    t_refuse();
    t_erase();
    t_abort();
    conclude();
  end
endmodule
`default_nettype wire
